/* File: design/alu_exec.sv */
// Execute datapath for a subset of an 8-bit core's instructions
//
// What this block does
// [RQ1] Pointer add sign-extends a 6-bit literal (-32..31) and adds it to pointer 0 or 1, flags untouched.
// [RQ2] The 16-bit pointer sum wraps modulo 65536 within 0000h..FFFFh.
// [RQ3] AND-immediate ANDs the accumulator with an 8-bit literal into the accumulator, updating only zero.
// [RQ4] Add-immediate adds an 8-bit literal to the accumulator, updating carry, half-carry and zero.
// [RQ5] AND-register ANDs the accumulator with a memory register to the d-chosen place, updating only zero.
// [RQ6] Add-register adds the accumulator and a register at a 7-bit address, updating carry, half-carry, zero.
// [RQ7] Register-source results except bit clear go to the accumulator when d is 0 and back to the register when d is 1.
// [RQ8] Add-with-carry sums accumulator, register and carry, updating carry, half-carry and zero.
// [RQ9] Signed right shift keeps bit 7, moves bits 7:1 down and bit 0 into carry, updating carry and zero.
// [RQ10] Bit clear zeroes the bit chosen by a 3-bit index in the register, leaving all flags alone.
// [RQ11] Pointer add is decoded from the pattern 11 0001 0nkk kkkk, n picking the pointer.
// [RQ12] An operand at an indirect access port whose pointer has its top bit set costs one extra cycle.
// [RQ13] For adds, carry is the carry out of bit 7 and half-carry out of bit 3; zero marks an all-zero 8-bit result.
`timescale 1ns/100ps
`include "alu_exec_regs.svh"

module alu_exec
    import alu_exec_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int PTR_W  = 16,
    parameter int ADDR_W = 7
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic              i_instr_valid,
    input  wire logic [13:0]       i_instr,
    input  wire logic [DATA_W-1:0] i_reg_data,
    output logic                   o_ready,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_accum,
    output logic                   o_carry,
    output logic                   o_nibble_overflow_flag,
    output logic                   o_zero,
    output logic [PTR_W-1:0]       o_indirect_pointer0,
    output logic [PTR_W-1:0]       o_indirect_pointer1,
    output logic                   o_reg_wr_en,
    output logic [ADDR_W-1:0]      o_reg_wr_addr,
    output logic [DATA_W-1:0]      o_reg_wr_data
);

    exec_state_t       state;
    logic [13:0]       held_instr;
    logic [DATA_W-1:0] held_data;

    logic [13:0]       cur_instr;
    logic [DATA_W-1:0] cur_data;
    exec_op_t          cur_op;
    exec_op_t          new_op;
    logic              execute;
    logic              needs_stretch;
    logic [ADDR_W-1:0] new_addr;

    logic [DATA_W-1:0] next_result;
    logic              next_carry;
    logic              next_nibble;
    logic              next_zero;
    logic              wr_carry;
    logic              wr_nibble;
    logic              wr_zero;
    logic              to_register;
    logic              to_accum;

    logic [DATA_W-1:0] add_a;
    logic [DATA_W-1:0] add_b;
    logic              add_cin;
    logic [DATA_W:0]   add_sum;
    logic [4:0]        add_low;

    logic [PTR_W-1:0]  ptr_sum;
    logic [PTR_W-1:0]  ptr_k_ext;
    logic [5:0]        ptr_k;

    // Pointer add and bit clear are matched first; their short prefixes must win over the six-bit table
    function automatic exec_op_t decode(input logic [13:0] ins);
        exec_op_t op;
        op = OP_NONE;
        if (ins[`OPC_PTR_MSB:`OPC_PTR_LSB] == `OPC_PTR_ADD) begin
            op = OP_POINTER_ADD_IMM; // [RQ11]
        end else if (ins[`OPC_BIT_MSB:`OPC_BIT_LSB] == `OPC_BIT_CLEAR) begin
            op = OP_BIT_CLEAR;
        end else begin
            case (ins[`OPC_HI_MSB:`OPC_HI_LSB])
                `OPC_ADD_IMM:       op = OP_ADD_IMMEDIATE;
                `OPC_AND_IMM:       op = OP_AND_IMMEDIATE;
                `OPC_AND_REG:       op = OP_AND_REGISTER;
                `OPC_ADD_REG:       op = OP_ADD_REGISTER;
                `OPC_SHR_SIGNED:    op = OP_SHIFT_RIGHT_SIGNED;
                `OPC_ADD_REG_CARRY: op = OP_ADD_REGISTER_CARRY;
                default:            op = OP_NONE;
            endcase
        end
        return op;
    endfunction : decode

    // Only operations that fetch a data-memory operand can land on an indirect port
    function automatic logic reads_register(input exec_op_t op);
        return (op == OP_AND_REGISTER) || (op == OP_ADD_REGISTER) || (op == OP_ADD_REGISTER_CARRY) ||
               (op == OP_SHIFT_RIGHT_SIGNED) || (op == OP_BIT_CLEAR);
    endfunction : reads_register

    // Stretch check on the incoming word
    always_comb begin
        new_op        = decode(i_instr);
        new_addr      = i_instr[`FLD_ADDR_MSB:`FLD_ADDR_LSB];
        needs_stretch = 1'b0;
        if (reads_register(new_op)) begin
            if (new_addr == `ADDR_INDIRECT_PORT0 && o_indirect_pointer0[PTR_W-1]) begin
                needs_stretch = 1'b1; // [RQ12]
            end
            if (new_addr == `ADDR_INDIRECT_PORT1 && o_indirect_pointer1[PTR_W-1]) begin
                needs_stretch = 1'b1; // [RQ12]
            end
        end
    end

    // The decoder must keep the word and operand only for the taking cycle; a stretched one is held here
    assign o_ready   = (state == ST_IDLE);
    assign execute   = (state == ST_STRETCH) || (i_instr_valid && !needs_stretch);
    assign cur_instr = (state == ST_STRETCH) ? held_instr : i_instr;
    assign cur_data  = (state == ST_STRETCH) ? held_data : i_reg_data;
    assign cur_op    = decode(cur_instr);

    // A stretched word spends one cycle here, then executes from the held copy
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (i_instr_valid && needs_stretch) begin
                        state <= ST_STRETCH; // [RQ12]
                    end
                end
                ST_STRETCH: state <= ST_IDLE;
                default:    state <= ST_IDLE;
            endcase
        end
    end

    // Captured on every offered word so the stretch cycle never relies on the decoder holding its bus
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            held_instr <= '0;
            held_data  <= '0;
        end else if (state == ST_IDLE && i_instr_valid) begin
            held_instr <= i_instr;
            held_data  <= i_reg_data;
        end
    end

    // One shared adder serves all three add forms
    always_comb begin
        add_a   = o_accum;
        add_b   = cur_data;
        add_cin = 1'b0;
        if (cur_op == OP_ADD_IMMEDIATE) begin
            add_b = cur_instr[`FLD_LIT_MSB:`FLD_LIT_LSB];
        end
        if (cur_op == OP_ADD_REGISTER_CARRY) begin
            add_cin = o_carry; // [RQ8]
        end
        add_sum = {1'b0, add_a} + {1'b0, add_b} + {{DATA_W{1'b0}}, add_cin};
        add_low = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
    end

    // Wraps naturally because the sum is cut to the pointer width
    always_comb begin
        ptr_k     = cur_instr[`FLD_PTR_K_MSB:`FLD_PTR_K_LSB];
        ptr_k_ext = {{(PTR_W-6){ptr_k[5]}}, ptr_k}; // [RQ1]
        if (cur_instr[`FLD_PTR_SEL]) begin
            ptr_sum = o_indirect_pointer1 + ptr_k_ext; // [RQ2]
        end else begin
            ptr_sum = o_indirect_pointer0 + ptr_k_ext; // [RQ2]
        end
    end

    // Flag values are formed for every operation but written only where the operation owns them
    always_comb begin
        next_result = '0;
        next_carry  = add_sum[DATA_W]; // [RQ13]
        next_nibble = add_low[4]; // [RQ13]
        wr_carry    = 1'b0;
        wr_nibble   = 1'b0;
        wr_zero     = 1'b0;
        to_register = 1'b0;
        to_accum    = 1'b0;
        case (cur_op)
            OP_AND_IMMEDIATE: begin
                next_result = o_accum & cur_instr[`FLD_LIT_MSB:`FLD_LIT_LSB]; // [RQ3]
                wr_zero     = 1'b1;
                to_accum    = 1'b1;
            end
            OP_ADD_IMMEDIATE: begin
                next_result = add_sum[DATA_W-1:0]; // [RQ4]
                wr_carry    = 1'b1;
                wr_nibble   = 1'b1;
                wr_zero     = 1'b1;
                to_accum    = 1'b1;
            end
            OP_AND_REGISTER: begin
                next_result = o_accum & cur_data; // [RQ5]
                wr_zero     = 1'b1;
            end
            OP_ADD_REGISTER, OP_ADD_REGISTER_CARRY: begin
                next_result = add_sum[DATA_W-1:0]; // [RQ6] [RQ8]
                wr_carry    = 1'b1;
                wr_nibble   = 1'b1;
                wr_zero     = 1'b1;
            end
            OP_SHIFT_RIGHT_SIGNED: begin
                next_result = {cur_data[DATA_W-1], cur_data[DATA_W-1:1]}; // [RQ9]
                next_carry  = cur_data[0]; // [RQ9]
                wr_carry    = 1'b1;
                wr_zero     = 1'b1;
            end
            OP_BIT_CLEAR: begin
                next_result = cur_data & ~(DATA_W'(1) << cur_instr[`FLD_BIT_MSB:`FLD_BIT_LSB]); // [RQ10]
                to_register = 1'b1;
            end
            default: begin
                next_result = '0;
            end
        endcase
        if (cur_op == OP_AND_REGISTER || cur_op == OP_ADD_REGISTER ||
            cur_op == OP_ADD_REGISTER_CARRY || cur_op == OP_SHIFT_RIGHT_SIGNED) begin
            to_register = cur_instr[`FLD_DEST]; // [RQ7]
            to_accum    = !cur_instr[`FLD_DEST]; // [RQ7]
        end
        next_zero = (next_result == '0); // [RQ13]
    end

    // Register-source results with the destination bit set leave the accumulator alone
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_accum <= `RST_ACCUM;
        end else if (execute && to_accum) begin
            o_accum <= next_result;
        end
    end

    // Flags are written only by the operations that own them
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_carry                <= `RST_FLAG;
            o_nibble_overflow_flag <= `RST_FLAG;
            o_zero                 <= `RST_FLAG;
        end else if (execute) begin
            if (wr_carry) begin
                o_carry <= next_carry;
            end
            if (wr_nibble) begin
                o_nibble_overflow_flag <= next_nibble;
            end
            if (wr_zero) begin
                o_zero <= next_zero;
            end
        end
    end

    // Pointer add never touches the flags or the accumulator
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_indirect_pointer0 <= `RST_POINTER;
            o_indirect_pointer1 <= `RST_POINTER;
        end else if (execute && cur_op == OP_POINTER_ADD_IMM) begin
            if (cur_instr[`FLD_PTR_SEL]) begin
                o_indirect_pointer1 <= ptr_sum; // [RQ1]
            end else begin
                o_indirect_pointer0 <= ptr_sum; // [RQ1]
            end
        end
    end

    // Write-back port: a one-cycle strobe with address and data held until the next write
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_wr_en   <= 1'b0;
            o_reg_wr_addr <= '0;
            o_reg_wr_data <= '0;
        end else begin
            o_reg_wr_en <= execute && to_register;
            if (execute && to_register) begin
                o_reg_wr_addr <= cur_instr[`FLD_ADDR_MSB:`FLD_ADDR_LSB];
                o_reg_wr_data <= next_result;
            end
        end
    end

    // Unknown words pulse done as well, so the decoder never waits on a no-op
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_done <= 1'b0;
        end else begin
            o_done <= execute;
        end
    end

endmodule : alu_exec

/* File: design/alu_exec_regs.svh */
// Opcode patterns, field positions and reset values for the execute datapath
`ifndef ALU_EXEC_REGS_SVH
`define ALU_EXEC_REGS_SVH

// Top six opcode bits of byte and literal instructions
`define OPC_HI_MSB            13
`define OPC_HI_LSB            8
`define OPC_ADD_IMM           6'h3E
`define OPC_AND_IMM           6'h39
`define OPC_AND_REG           6'h05
`define OPC_ADD_REG           6'h07
`define OPC_SHR_SIGNED        6'h37
`define OPC_ADD_REG_CARRY     6'h3D
// Pointer add: 11 0001 0nkk kkkk, top seven bits
`define OPC_PTR_MSB           13
`define OPC_PTR_LSB           7
`define OPC_PTR_ADD           7'h62
// Bit clear: 01 00bb bfff ffff, top four bits
`define OPC_BIT_MSB           13
`define OPC_BIT_LSB           10
`define OPC_BIT_CLEAR         4'h4

// Field positions
`define FLD_DEST              7
`define FLD_ADDR_MSB          6
`define FLD_ADDR_LSB          0
`define FLD_LIT_MSB           7
`define FLD_LIT_LSB           0
`define FLD_PTR_SEL           6
`define FLD_PTR_K_MSB         5
`define FLD_PTR_K_LSB         0
`define FLD_BIT_MSB           9
`define FLD_BIT_LSB           7

// Data-memory addresses of the two indirect access ports
`define ADDR_INDIRECT_PORT0   7'h00
`define ADDR_INDIRECT_PORT1   7'h01

// Reset values
`define RST_ACCUM             8'h00
`define RST_POINTER           16'h0000
`define RST_FLAG              1'b0

`endif

/* File: design/alu_exec_pkg.sv */
// Types shared by the execute datapath
package alu_exec_pkg;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_STRETCH
    } exec_state_t;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_POINTER_ADD_IMM,
        OP_AND_IMMEDIATE,
        OP_ADD_IMMEDIATE,
        OP_AND_REGISTER,
        OP_ADD_REGISTER,
        OP_ADD_REGISTER_CARRY,
        OP_SHIFT_RIGHT_SIGNED,
        OP_BIT_CLEAR
    } exec_op_t;

endpackage : alu_exec_pkg

/* File: test/alu_exec_properties.sv */
// Port-level timing and result checks for the execute datapath
`timescale 1ns/100ps
module alu_exec_properties (
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic        i_instr_valid,
    input wire logic [13:0] i_instr,
    input wire logic [7:0]  i_reg_data,
    input wire logic        o_ready,
    input wire logic        o_done,
    input wire logic [7:0]  o_accum,
    input wire logic        o_carry,
    input wire logic        o_nibble_overflow_flag,
    input wire logic        o_zero,
    input wire logic [15:0] o_indirect_pointer0,
    input wire logic        o_reg_wr_en,
    input wire logic [7:0]  o_reg_wr_data
);
    logic       take;
    logic       quick;
    logic [5:0] hi;
    logic [2:0] flags;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    assign take  = i_instr_valid && o_ready;
    assign hi    = i_instr[13:8];
    assign flags = {o_carry, o_nibble_overflow_flag, o_zero};
    // Addresses 2 and up never reach an indirect port, so no stretch
    assign quick = i_instr[6:1] != 6'h00;
    AST_DONE_BOUND: assert property (take |=> (o_done or (!o_ready ##1 o_done)))
        else $error("done pulse missing");
    AST_READY_ONE: assert property (!o_ready |=> o_ready)
        else $error("stretch longer than one cycle");
    AST_STRETCH: assert property (take && hi == 6'h07 && i_instr[6:0] == 7'h00 && o_indirect_pointer0[15]
        |=> !o_ready && !o_done) else $error("stretch not taken");
    AST_PTR_SUM: assert property (take && i_instr[13:6] == 8'hC4 |=> o_indirect_pointer0 ==
        16'($past(o_indirect_pointer0) + {{10{$past(i_instr[5])}}, $past(i_instr[5:0])}))
        else $error("pointer sum wrong");
    AST_PTR_FLAGS: assert property (take && i_instr[13:7] == 7'h62 |=> $stable(flags) && $stable(o_accum))
        else $error("pointer add touched state");
    AST_AND_IMM: assert property (take && hi == 6'h39 |=> o_accum == ($past(o_accum) & $past(i_instr[7:0]))
        && o_zero == (o_accum == 8'h00) && $stable(o_carry)) else $error("and immediate wrong");
    AST_ADD_IMM: assert property (take && hi == 6'h3E
        |=> {o_carry, o_accum} == {1'b0, $past(o_accum)} + {1'b0, $past(i_instr[7:0])})
        else $error("add immediate wrong");
    AST_HALF: assert property (take && hi == 6'h3E |=> o_nibble_overflow_flag ==
        ({1'b0, $past(o_accum[3:0])} + {1'b0, $past(i_instr[3:0])} > 5'h0F)) else $error("half carry wrong");
    AST_DEST: assert property (take && quick && (hi == 6'h05 || hi == 6'h07)
        |=> o_reg_wr_en == $past(i_instr[7])) else $error("destination wrong");
    AST_BCLR: assert property (take && quick && i_instr[13:10] == 4'h4 |=> o_reg_wr_en && $stable(flags) &&
        o_reg_wr_data == ($past(i_reg_data) & ~(8'h01 << $past(i_instr[9:7])))) else $error("bit clear wrong");
    AST_SHIFT: assert property (take && quick && hi == 6'h37 |=> o_carry == $past(i_reg_data[0]))
        else $error("shift carry wrong");
endmodule : alu_exec_properties

/* File: test/alu_exec_mem_model.sv */
// Data-memory partner: answers the addressed register, takes write-backs
`timescale 1ns/100ps
module alu_exec_mem_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_valid,
    input  wire logic [6:0] i_addr,
    input  wire logic       i_wr_en,
    input  wire logic [6:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_rd_data
);
    logic [7:0] mem [128];
    initial for (int a = 0; a < 128; a++) mem[a] = 8'(a * 37 + 5);
    always @(posedge i_clk_sys) if (i_wr_en) mem[i_wr_addr] <= i_wr_data;
    // Outside an offered word the bus shows the inverse, so stale data cannot pass
    assign o_rd_data = i_valid ? mem[i_addr] : ~mem[i_addr];
endmodule : alu_exec_mem_model

/* File: test/mcu_alu_execute_subset_tb_top.sv */
// Bench comparing the execute datapath with an integer model
`timescale 1ns/100ps
module mcu_alu_execute_subset_tb_top;
    import alu_exec_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        vld = 1'b0;
    logic [13:0] ins = 14'h0000;
    logic [7:0]  rdat, acc_o, wdat;
    logic [15:0] ptr0, ptr1;
    logic [6:0]  wadr;
    logic        rdy, done, cy, hc, zf, wen;
    logic [5:0]  ops [4] = '{6'h05, 6'h07, 6'h3D, 6'h37};
    int          bad_count, compares, acc, c, nib, z, lwa, lwd;
    int          p [2];
    int          mem [128];
    always #25 clk = ~clk;
    alu_exec i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(ins), .i_reg_data(rdat),
        .o_ready(rdy), .o_done(done), .o_accum(acc_o), .o_carry(cy), .o_nibble_overflow_flag(hc), .o_zero(zf),
        .o_indirect_pointer0(ptr0), .o_indirect_pointer1(ptr1), .o_reg_wr_en(wen), .o_reg_wr_addr(wadr),
        .o_reg_wr_data(wdat));
    alu_exec_mem_model i_mem (.i_clk_sys(clk), .i_valid(vld), .i_addr(ins[6:0]), .i_wr_en(wen),
        .i_wr_addr(wadr), .i_wr_data(wdat), .o_rd_data(rdat));
    task automatic chk(input logic [15:0] g, input int e, input string m);
        compares++;
        if (g !== 16'(e)) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, 16'(e));
        end
    endtask : chk
    task automatic state(input int we);
        chk(acc_o, acc, "accum");
        chk({cy, hc, zf}, c * 4 + nib * 2 + z, "flags");
        chk(ptr0, p[0], "pointer0");
        chk(ptr1, p[1], "pointer1");
        chk({wen, wadr, wdat}, we * 32768 + lwa * 256 + lwd, "write");
    endtask : state
    task automatic run(input logic [13:0] w);
        int f, r, op, st, we, res, b, ci;
        f = w[6:0];
        r = mem[f];
        op = w[13:8];
        res = -1;
        we = 0;
        st = f < 2 && p[f][15] && (op inside {6'h05, 6'h07, 6'h3D, 6'h37} || w[13:10] == 4'h4);
        @(posedge clk);
        ins <= w;
        vld <= 1'b1;
        if (w[13:7] == 7'h62) begin
            b = $signed(w[5:0]);
            p[w[6]] = (p[w[6]] + b) & 32'h0000_FFFF;
        end
        if (op == 6'h39 || op == 6'h05) res = acc & (op == 6'h39 ? w[7:0] : r);
        if (op inside {6'h3E, 6'h07, 6'h3D}) begin
            b = (op == 6'h3E) ? w[7:0] : r;
            ci = (op == 6'h3D) ? c : 0;
            res = acc + b + ci;
            nib = ((acc & 15) + (b & 15) + ci) > 15;
            c = res > 255;
        end
        if (op == 6'h37) begin
            res = (r & 128) | (r >> 1);
            c = r & 1;
        end
        if (w[13:10] == 4'h4) res = r & ~(1 << w[9:7]);
        if (res >= 0) begin
            res = res & 255;
            if (w[13:10] != 4'h4) z = (res == 0);
            if (w[13:10] == 4'h4 || (w[7] && !(op inside {6'h39, 6'h3E}))) begin
                we = 1;
                lwa = f;
                lwd = res;
                mem[f] = res;
            end
            else acc = res;
        end
        @(posedge clk);
        vld <= 1'b0;
        if (st) begin
            #1;
            chk({rdy, done}, 0, "stretch");
            @(posedge clk);
        end
        #1;
        chk({rdy, done}, 3, "done");
        state(we);
    endtask : run
    task automatic test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        int k;
        void'($urandom(41215));
        for (int a = 0; a < 128; a++) mem[a] = (a * 37 + 5) & 255;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({rdy, done}, 2, "reset");
        state(0);
        $display("test reset done");
        run({6'h3E, 8'hFF});
        run({6'h3E, 8'h01});
        run({6'h39, 8'hFF});
        repeat (20) run({$urandom_range(1) ? 6'h39 : 6'h3E, 8'($urandom)});
        $display("test immediates done");
        // Walk both pointers across the top of the range to force stretches and wraps
        run({7'h62, 1'b0, 6'h20});
        run({7'h62, 1'b1, 6'h1F});
        run({6'h07, 1'b1, 7'h00});
        run({7'h62, 1'b1, 6'h20});
        run({4'h4, 3'h5, 7'h01});
        run({7'h62, 1'b0, 6'h1F});
        run({7'h62, 1'b0, 6'h01});
        run({6'h07, 1'b0, 7'h00});
        run(14'h3FFF);
        $display("test pointers done");
        repeat (150) begin
            k = $urandom_range(5);
            if (k == 5) run({7'h62, 7'($urandom)});
            else if (k == 4) run({4'h4, 10'($urandom)});
            else run({ops[k], 8'($urandom)});
        end
        $display("test random done");
        test_done();
    end
    initial begin
        #100_000;
        bad_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        test_done();
    end
endmodule : mcu_alu_execute_subset_tb_top
bind alu_exec alu_exec_properties i_props (.i_clk_sys, .i_sys_rst, .i_instr_valid, .i_instr, .i_reg_data,
    .o_ready, .o_done, .o_accum, .o_carry, .o_nibble_overflow_flag, .o_zero, .o_indirect_pointer0,
    .o_reg_wr_en, .o_reg_wr_data);
